// >>> pcat_pkg.sv
// Purpose: constants for the counter array time base and control
// Assumes: 8-bit special function register port, one 200 MHz clock
// Notes:   offsets are special function register addresses
package pcat_pkg;
    localparam logic [7:0] MODE_ADDR      = 8'hd9;
    localparam logic [7:0] CTRL_ADDR      = 8'hd8;
    localparam logic [7:0] CNT_LO_ADDR    = 8'he9;
    localparam logic [7:0] CNT_HI_ADDR    = 8'hf9;
    localparam int         MODE_IDLE_BIT  = 7;
    localparam int         MODE_WDT_BIT   = 6;
    localparam int         MODE_SRC_HI    = 2;
    localparam int         MODE_SRC_LO    = 1;
    localparam int         MODE_IE_BIT    = 0;
    localparam logic [7:0] MODE_WR_MASK   = 8'hc7;
    localparam logic [7:0] MODE_RESET     = 8'h00;
    localparam int         CTRL_OVF_BIT   = 7;
    localparam int         CTRL_RUN_BIT   = 6;
    localparam int         NUM_MODULES    = 5;
    localparam logic [7:0] CTRL_RESET     = 8'h00;
    localparam logic [2:0] DIV_SIX_LAST   = 3'h5;
    localparam logic [1:0] SRC_DIV6       = 2'h0;
    localparam logic [1:0] SRC_DIV2       = 2'h1;
    localparam logic [1:0] SRC_T0         = 2'h2;
    localparam logic [1:0] SRC_EXT        = 2'h3;
endpackage

// >>> pcat_prescale.sv
// Purpose: turns the selected count source into one-cycle advance pulses
// Assumes: external input already synchronised by the caller
// Notes:   dividers run only while counting is allowed
module pcat_prescale (
    // Clock and reset
    input  wire logic  i_clk,
    input  wire logic  i_srst,
    // Sources
    input  wire logic  i_t0_ovf,
    input  wire logic  i_ext_sync,
    // Tick carrier
    pcat_tick_if.pre   tk
);
    logic [2:0] div_q;
    logic [2:0] div_d;
    logic       ext_q;
    logic       ext_d;
    logic       tick;

    always_comb begin
        div_d = div_q;
        ext_d = i_ext_sync;
        tick  = 1'b0;
        if (tk.run) begin
            div_d = (div_q == pcat_pkg::DIV_SIX_LAST) ? 3'h0 : div_q + 3'h1;
        end
        case (tk.src)
            pcat_pkg::SRC_DIV6: tick = tk.run && (div_q == pcat_pkg::DIV_SIX_LAST);
            pcat_pkg::SRC_DIV2: tick = tk.run && div_q[0];
            pcat_pkg::SRC_T0:   tick = tk.run && i_t0_ovf;
            // Rising edge only; source must stay below a quarter rate
            pcat_pkg::SRC_EXT:  tick = tk.run && i_ext_sync && !ext_q;
            default:            tick = 1'b0;
        endcase
    end

    always_ff @(posedge i_clk) begin
        if (i_srst) begin
            div_q <= 3'h0;
            ext_q <= 1'b0;
        end else begin
            div_q <= div_d;
            ext_q <= ext_d;
        end
    end

    assign tk.tick = tick;

    div_six_a: assert property (@(posedge i_clk) disable iff (i_srst)
        tk.run && tk.src == pcat_pkg::SRC_DIV6 && tk.tick |=>
        (!(tk.tick && tk.src == pcat_pkg::SRC_DIV6)) [*5])
        else $error("divide by six ticks too close");
endmodule

// >>> pcat_tick_if.sv
// Purpose: carries the count-advance tick between prescaler and counter
// Assumes: single clock domain
// Notes:   tick is a one-cycle enable
interface pcat_tick_if;
    logic [1:0] src;
    logic       run;
    logic       tick;
    modport ctrl (output src, output run, input tick);
    modport pre  (input src, input run, output tick);
endinterface

// >>> pcat_top.sv
// Purpose: time base and control of a programmable counter array
// Assumes: special function register port, one 200 MHz clock
// Notes:   compare and capture datapaths live outside this block
module pcat_top #(
    parameter int CNT_W = 16
) (
    // Clock and reset
    input  wire logic             i_clk,
    input  wire logic             i_srst,
    // Register port
    input  wire logic [7:0]       i_addr,
    input  wire logic             i_wr,
    input  wire logic             i_bit_wr,
    input  wire logic [7:0]       i_wdata,
    output logic      [7:0]       o_rdata,
    // System status and sources
    input  wire logic             i_idle,
    input  wire logic             i_t0_ovf,
    input  wire logic             i_ext_count,
    input  wire logic [4:0]       i_module_event,
    // Results
    output logic                  o_irq,
    output logic                  o_watchdog_en,
    output logic                  o_running,
    output logic      [CNT_W-1:0] o_count
);
    logic [7:0]       mode_q;
    logic [7:0]       mode_d;
    logic [7:0]       ctrl_q;
    logic [7:0]       ctrl_d;
    logic [CNT_W-1:0] cnt_q;
    logic [CNT_W-1:0] cnt_d;
    logic [7:0]       rdata_d;
    logic             irq_d;
    logic             run_d;
    logic             ext_meta_q;
    logic             ext_sync_q;
    logic             wrap;
    logic             mode_wr;
    logic             ctrl_wr;
    logic             cnt_wr;

    pcat_tick_if tk ();

    // Pin passes two flops before the edge detector sees it
    always_ff @(posedge i_clk) begin
        if (i_srst) begin
            ext_meta_q <= 1'b0;
            ext_sync_q <= 1'b0;
        end else begin
            ext_meta_q <= i_ext_count;
            ext_sync_q <= ext_meta_q;
        end
    end

    // Idle gating stops the prescaler too, so no partial tick leaks out
    assign tk.src = {mode_q[pcat_pkg::MODE_SRC_HI], mode_q[pcat_pkg::MODE_SRC_LO]};
    assign tk.run = ctrl_q[pcat_pkg::CTRL_RUN_BIT] &&
                    !(i_idle && mode_q[pcat_pkg::MODE_IDLE_BIT]);

    pcat_prescale u_pre (
        .i_clk      (i_clk),
        .i_srst     (i_srst),
        .i_t0_ovf   (i_t0_ovf),
        .i_ext_sync (ext_sync_q),
        .tk         (tk)
    );

    assign mode_wr = i_wr && !i_bit_wr && (i_addr == pcat_pkg::MODE_ADDR);
    assign ctrl_wr = i_wr && (i_addr == pcat_pkg::CTRL_ADDR);
    assign wrap    = tk.tick && (&cnt_q);
    assign cnt_wr  = i_wr && (i_addr == pcat_pkg::CNT_LO_ADDR ||
                              i_addr == pcat_pkg::CNT_HI_ADDR);

    always_comb begin
        mode_d = mode_q;
        ctrl_d = ctrl_q;
        cnt_d  = cnt_q;
        if (mode_wr) begin
            // Reserved bits are never stored, so they read back as zero
            mode_d = i_wdata & pcat_pkg::MODE_WR_MASK;
        end
        if (ctrl_wr) begin
            ctrl_d = i_wdata;
        end
        if (tk.tick) begin
            cnt_d = cnt_q + {{(CNT_W-1){1'b0}}, 1'b1};
        end
        if (i_wr && i_addr == pcat_pkg::CNT_LO_ADDR) begin
            cnt_d[7:0] = i_wdata;
        end
        if (i_wr && i_addr == pcat_pkg::CNT_HI_ADDR) begin
            cnt_d[CNT_W-1:8] = i_wdata[CNT_W-9:0];
        end
        // Hardware set wins over a software clear in the same cycle
        if (wrap) begin
            ctrl_d[pcat_pkg::CTRL_OVF_BIT] = 1'b1;
        end
        ctrl_d[4:0] = ctrl_d[4:0] | i_module_event;
        ctrl_d[5]   = 1'b0;
        case (i_addr)
            pcat_pkg::MODE_ADDR:   rdata_d = mode_d;
            pcat_pkg::CTRL_ADDR:   rdata_d = ctrl_d;
            pcat_pkg::CNT_LO_ADDR: rdata_d = cnt_d[7:0];
            pcat_pkg::CNT_HI_ADDR: rdata_d = cnt_d[CNT_W-1:8];
            default:               rdata_d = 8'h00;
        endcase
        irq_d = ctrl_d[pcat_pkg::CTRL_OVF_BIT] && mode_d[pcat_pkg::MODE_IE_BIT];
        run_d = ctrl_d[pcat_pkg::CTRL_RUN_BIT];
    end

    always_ff @(posedge i_clk) begin
        if (i_srst) begin
            mode_q        <= pcat_pkg::MODE_RESET;
            ctrl_q        <= pcat_pkg::CTRL_RESET;
            cnt_q         <= '0;
            o_rdata       <= 8'h00;
            o_irq         <= 1'b0;
            o_watchdog_en <= 1'b0;
            o_running     <= 1'b0;
            o_count       <= '0;
        end else begin
            mode_q        <= mode_d;
            ctrl_q        <= ctrl_d;
            cnt_q         <= cnt_d;
            o_rdata       <= rdata_d;
            o_irq         <= irq_d;
            o_watchdog_en <= mode_d[pcat_pkg::MODE_WDT_BIT];
            o_running     <= run_d;
            o_count       <= cnt_d;
        end
    end

    sequence s_wrap;
        tk.tick && (&cnt_q);
    endsequence

    ovf_sets_a: assert property (@(posedge i_clk) disable iff (i_srst)
        s_wrap |=> ctrl_q[pcat_pkg::CTRL_OVF_BIT] && (cnt_q == '0 || $past(cnt_wr)))
        else $error("overflow flag not set on wrap");
    ovf_sticky_a: assert property (@(posedge i_clk) disable iff (i_srst)
        ctrl_q[pcat_pkg::CTRL_OVF_BIT] && !ctrl_wr |=> ctrl_q[pcat_pkg::CTRL_OVF_BIT])
        else $error("overflow flag cleared by hardware");
    mod_flags_a: assert property (@(posedge i_clk) disable iff (i_srst)
        i_module_event[4] |=> ctrl_q[4])
        else $error("module flag lost");
    irq_gate_a: assert property (@(posedge i_clk) disable iff (i_srst)
        o_irq == (ctrl_q[pcat_pkg::CTRL_OVF_BIT] && mode_q[pcat_pkg::MODE_IE_BIT]))
        else $error("interrupt not gated by enable");
    idle_stop_a: assert property (@(posedge i_clk) disable iff (i_srst)
        i_idle && mode_q[7] && !i_wr |=> cnt_q == $past(cnt_q))
        else $error("counter moved in gated idle");
    stop_run_a: assert property (@(posedge i_clk) disable iff (i_srst)
        !ctrl_q[6] && !i_wr |=> cnt_q == $past(cnt_q))
        else $error("counter moved while stopped");
    reserved_a: assert property (@(posedge i_clk) disable iff (i_srst)
        mode_q[5:3] == 3'h0)
        else $error("reserved mode bits stored");
    bit_wr_a: assert property (@(posedge i_clk) disable iff (i_srst)
        i_wr && i_bit_wr && i_addr == pcat_pkg::MODE_ADDR |=> $stable(mode_q))
        else $error("mode changed by bit write");
    wdt_out_a: assert property (@(posedge i_clk) disable iff (i_srst)
        ##1 o_watchdog_en == mode_q[6])
        else $error("watchdog enable mismatch");

    // Tick spacing per source; a source switch restarts the check
    sequence s_div2_tick;
        tk.run && tk.src == pcat_pkg::SRC_DIV2 && tk.tick;
    endsequence

    sequence s_div2_run;
        tk.run && tk.src == pcat_pkg::SRC_DIV2;
    endsequence

    div_two_a: assert property (@(posedge i_clk) disable iff (i_srst)
        s_div2_tick ##1 s_div2_run ##1 s_div2_run |-> tk.tick && !$past(tk.tick))
        else $error("divide by two ticks misplaced");
    t0_src_a: assert property (@(posedge i_clk) disable iff (i_srst)
        tk.src == pcat_pkg::SRC_T0 |-> tk.tick == (tk.run && i_t0_ovf))
        else $error("timer overflow source miscounted");
    ext_src_a: assert property (@(posedge i_clk) disable iff (i_srst)
        tk.src == pcat_pkg::SRC_EXT && tk.run |-> tk.tick == (ext_sync_q && !$past(ext_sync_q)))
        else $error("external edge miscounted");
    count_step_a: assert property (@(posedge i_clk) disable iff (i_srst)
        tk.tick && !cnt_wr |=> cnt_q - $past(cnt_q) == {{(CNT_W-1){1'b0}}, 1'b1})
        else $error("counter did not advance by one");
    count_hold_a: assert property (@(posedge i_clk) disable iff (i_srst)
        !tk.tick && !cnt_wr |=> $stable(cnt_q))
        else $error("counter moved without a tick");
    out_copy_a: assert property (@(posedge i_clk) disable iff (i_srst)
        o_count == cnt_q && o_running == ctrl_q[pcat_pkg::CTRL_RUN_BIT])
        else $error("count or run output stale");
    ovf_clear_a: assert property (@(posedge i_clk) disable iff (i_srst)
        ctrl_wr && !i_wdata[pcat_pkg::CTRL_OVF_BIT] && !wrap
        |=> !ctrl_q[pcat_pkg::CTRL_OVF_BIT])
        else $error("overflow flag not cleared by software");
    idle_run_a: assert property (@(posedge i_clk) disable iff (i_srst)
        i_idle && !mode_q[pcat_pkg::MODE_IDLE_BIT]
        |-> tk.run == ctrl_q[pcat_pkg::CTRL_RUN_BIT])
        else $error("counter stopped in ungated idle");
    mode_wr_a: assert property (@(posedge i_clk) disable iff (i_srst)
        mode_wr |=> mode_q == ($past(i_wdata) & pcat_pkg::MODE_WR_MASK))
        else $error("mode write not stored");

    // Per-module flags: set by events, held until software clears
    for (genvar n = 0; n < pcat_pkg::NUM_MODULES; n++) begin : g_flag
        flag_set_a: assert property (@(posedge i_clk) disable iff (i_srst)
            i_module_event[n] |=> ctrl_q[n])
            else $error("module flag not set");
        flag_keep_a: assert property (@(posedge i_clk) disable iff (i_srst)
            ctrl_q[n] && !ctrl_wr |=> ctrl_q[n])
            else $error("module flag cleared by hardware");
    end
endmodule

// >>> tb_pcat_top.sv
// Purpose: self-checking bench for the counter array time base
// Assumes: pcat_top with a 16-bit count, one 200 MHz clock
// Notes:   rates are checked as count deltas over fixed spans
module tb_pcat_top;
    timeunit 1ns;
    timeprecision 1ps;
    logic        i_clk = 1'b0;
    logic        i_srst = 1'b1;
    logic [7:0]  i_addr = 8'h00;
    logic        i_wr = 1'b0;
    logic        i_bit_wr = 1'b0;
    logic [7:0]  i_wdata = 8'h00;
    logic        i_idle = 1'b0;
    logic        i_t0_ovf = 1'b0;
    logic        i_ext_count = 1'b0;
    logic [4:0]  i_module_event = 5'h00;
    logic [7:0]  o_rdata;
    logic        o_irq;
    logic        o_watchdog_en;
    logic        o_running;
    logic [15:0] o_count;
    logic [15:0] lfsr = 16'hbb97;
    logic [15:0] c0;
    logic [4:0]  ev;
    int          n_errors = 0;
    int          n_compared = 0;

    always #2.5 i_clk = ~i_clk;

    pcat_top dut (.i_clk(i_clk), .i_srst(i_srst), .i_addr(i_addr), .i_wr(i_wr),
        .i_bit_wr(i_bit_wr), .i_wdata(i_wdata), .o_rdata(o_rdata), .i_idle(i_idle),
        .i_t0_ovf(i_t0_ovf), .i_ext_count(i_ext_count), .i_module_event(i_module_event),
        .o_irq(o_irq), .o_watchdog_en(o_watchdog_en), .o_running(o_running),
        .o_count(o_count));

    function automatic logic [15:0] lfsr_next(input logic [15:0] s);
        return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
    endfunction

    // Steady-state ticks over a span for the two divided sources
    function automatic logic [15:0] exp_delta(input logic [1:0] src, input int span);
        return (src == pcat_pkg::SRC_DIV6) ? 16'(span / 6) : 16'(span / 2);
    endfunction

    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        n_compared++;
        if (got !== exp) begin
            n_errors++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] d, input logic bw = 1'b0);
        @(posedge i_clk);
        i_wr <= 1'b1;
        i_addr <= a;
        i_wdata <= d;
        i_bit_wr <= bw;
        @(posedge i_clk);
        i_wr <= 1'b0;
        i_bit_wr <= 1'b0;
    endtask

    task automatic rd(input logic [7:0] a, input logic [7:0] e);
        @(posedge i_clk);
        i_addr <= a;
        @(posedge i_clk);
        #1;
        chk(16'(o_rdata), 16'(e));
    endtask

    // Settle first so a source change never splits the span
    task automatic rate(input logic [15:0] exp, input int span);
        repeat (12) @(posedge i_clk);
        #1;
        c0 = o_count;
        repeat (span) @(posedge i_clk);
        #1;
        chk(o_count - c0, exp);
    endtask

    // Both sources pulse together, so only the selected one may count
    task automatic pulses(input int n);
        repeat (4) @(posedge i_clk);
        #1;
        c0 = o_count;
        for (int i = 0; i < n; i++) begin
            @(posedge i_clk);
            i_t0_ovf <= 1'b1;
            i_ext_count <= 1'b1;
            @(posedge i_clk);
            i_t0_ovf <= 1'b0;
            repeat (3) @(posedge i_clk);
            i_ext_count <= 1'b0;
            repeat (3) @(posedge i_clk);
        end
        repeat (8) @(posedge i_clk);
        #1;
        chk(o_count - c0, 16'(n));
    endtask

    task automatic end_of_test;
        $display("n_errors=%0d n_compared=%0d", n_errors, n_compared);
        if (n_errors == 0 && n_compared > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask

    initial begin
        repeat (20000) @(posedge i_clk);
        n_errors++;
        end_of_test();
    end

    initial begin
        repeat (10) @(posedge i_clk);
        i_srst <= 1'b0;
        rd(pcat_pkg::MODE_ADDR, pcat_pkg::MODE_RESET);
        rd(pcat_pkg::CTRL_ADDR, pcat_pkg::CTRL_RESET);
        wr(pcat_pkg::MODE_ADDR, pcat_pkg::MODE_WR_MASK);
        rd(pcat_pkg::MODE_ADDR, pcat_pkg::MODE_WR_MASK);
        chk(16'(o_watchdog_en), 16'h1);
        wr(pcat_pkg::MODE_ADDR, 8'h00, 1'b1);
        rd(pcat_pkg::MODE_ADDR, pcat_pkg::MODE_WR_MASK);
        wr(pcat_pkg::MODE_ADDR, 8'h00);
        rd(pcat_pkg::MODE_ADDR, 8'h00);
        chk(16'(o_watchdog_en), 16'h0);
        wr(pcat_pkg::CTRL_ADDR, 8'h40);
        rd(pcat_pkg::CTRL_ADDR, 8'h40);
        chk(16'(o_running), 16'h1);
        for (int s = 0; s < 2; s++) begin
            wr(pcat_pkg::MODE_ADDR, {5'h00, 2'(s), 1'b0});
            rate(exp_delta(2'(s), 60), 60);
        end
        @(posedge i_clk);
        i_idle <= 1'b1;
        rate(16'd30, 60);
        wr(pcat_pkg::MODE_ADDR, 8'h82);
        rate(16'h0000, 60);
        @(posedge i_clk);
        i_idle <= 1'b0;
        rate(16'd30, 60);
        for (int s = 2; s < 4; s++) begin
            lfsr = lfsr_next(lfsr);
            wr(pcat_pkg::MODE_ADDR, {5'h00, 2'(s), 1'b0});
            pulses(int'(lfsr[2:0]) + 1);
        end
        wr(pcat_pkg::CTRL_ADDR, 8'h00);
        rate(16'h0000, 60);
        chk(16'(o_running), 16'h0);
        // Start just below the wrap, with and without the interrupt enable
        for (int ie = 1; ie >= 0; ie--) begin
            wr(pcat_pkg::CTRL_ADDR, 8'h00);
            wr(pcat_pkg::MODE_ADDR, {6'h01, ie[0]});
            wr(pcat_pkg::CNT_LO_ADDR, 8'hf0);
            wr(pcat_pkg::CNT_HI_ADDR, 8'hff);
            wr(pcat_pkg::CTRL_ADDR, 8'h40);
            repeat (60) @(posedge i_clk);
            rd(pcat_pkg::CTRL_ADDR, 8'hc0);
            chk(16'(o_irq), 16'(ie));
        end
        wr(pcat_pkg::CTRL_ADDR, 8'h40);
        rd(pcat_pkg::CTRL_ADDR, 8'h40);
        for (int i = 0; i < 4; i++) begin
            lfsr = lfsr_next(lfsr);
            ev = (i == 0) ? 5'h1f : lfsr[4:0];
            @(posedge i_clk);
            i_module_event <= ev;
            @(posedge i_clk);
            i_module_event <= 5'h00;
            rd(pcat_pkg::CTRL_ADDR, {3'h2, ev});
            wr(pcat_pkg::CTRL_ADDR, 8'h40);
            rd(pcat_pkg::CTRL_ADDR, 8'h40);
        end
        // Reset in mid-run must return every register to its reset value
        wr(pcat_pkg::MODE_ADDR, pcat_pkg::MODE_WR_MASK);
        @(posedge i_clk);
        i_srst <= 1'b1;
        repeat (2) @(posedge i_clk);
        i_srst <= 1'b0;
        rd(pcat_pkg::MODE_ADDR, pcat_pkg::MODE_RESET);
        rd(pcat_pkg::CTRL_ADDR, pcat_pkg::CTRL_RESET);
        chk(16'(o_watchdog_en), 16'h0);
        chk(o_count, 16'h0000);
        end_of_test();
    end
endmodule
